// [core/ida_consts.vh]
// Register map, field positions, reset values and codes of the unit.
`ifndef IDA_CONSTS_VH
`define IDA_CONSTS_VH

// ============================================================
// Physical register byte offsets (low byte of the AHB address).
`define IDA_OFF_P0_LOW 8'h00
`define IDA_OFF_P0_HIGH 8'h04
`define IDA_OFF_P1_LOW 8'h08
`define IDA_OFF_P1_HIGH 8'h0c
`define IDA_OFF_P2_LOW 8'h10
`define IDA_OFF_P2_HIGH 8'h14
`define IDA_OFF_WORK 8'h18
`define IDA_OFF_BANK 8'h1c
`define IDA_OFF_STATUS 8'h20

// ============================================================
// Virtual register window: address bits [7:5] pick the pointer,
// bits [4:2] pick the access mode.
`define IDA_VPTR_LSB 5
`define IDA_VPTR_MSB 7
`define IDA_VMODE_LSB 2
`define IDA_VMODE_MSB 4
`define IDA_VPTR_FIRST 3'h2
`define IDA_VPTR_LAST 3'h4
`define IDA_MODE_PLAIN 3'h0
`define IDA_MODE_AFTER_UP 3'h1
`define IDA_MODE_AFTER_DOWN 3'h2
`define IDA_MODE_BEFORE_UP 3'h3
`define IDA_MODE_OFFSET 3'h4

// ============================================================
// Field positions and widths.
`define IDA_HIGH_MSB 11
`define IDA_HIGH_LSB 8
`define IDA_LOW_MSB 7
`define IDA_LOW_LSB 0

// ============================================================
// Reset values.
`define IDA_RST_HIGH 4'h0
`define IDA_RST_LOW 8'h00
`define IDA_RST_BANK 4'h0
`define IDA_RST_WORK 8'h00
`define IDA_RST_EA 12'h000

`endif

// [core/ida_core.v]
// Indirect data addressing unit with an AHB-Lite register slave.
//
// What this block does
// [RL1] Plain access through pointer two uses it unchanged; nothing stored.
// [RL2] After-up access through pointer two uses it, then adds one.
// [RL3] After-down access through pointer two uses it, then subtracts one.
// [RL4] Before-up access through pointer two adds one, then uses it.
// [RL5] Before-up access through pointer one adds one, then uses it.
// [RL6] Offset access through pointer one addresses pointer plus working.
// [RL7] Offset access through pointer zero addresses pointer plus working.
// [RL8] Plain access through pointer zero uses it and leaves it alone.
// [RL9] Reset clears the implemented bits of pointer one high byte.
// [RL10] Pointer one low byte holds eight bits; its reset value is unknown. The code clears it to zero at reset.
// [RL11] Reset clears the implemented bits of the bank select register.
// [RL12] Reset clears the implemented bits of pointer two high byte.
// [RL13] Pointers are twelve bits; steps carry or borrow across bytes.
// [RL14] Offset is an unsigned add and never changes the pointer.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ida_consts.vh"

module ida_core #(
    parameter AW = 12,
    parameter NPTR = 3
) (
    input wire MCLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    output reg [3:0] BANK_SELECT
);

    // ============================================================
    // Bus transaction state
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg state_reg;
    reg state_next;
    reg [7:0] addr_reg;
    reg hit_reg;
    reg write_reg;
    reg [7:0] work_reg;
    reg [AW-1:0] last_ea_reg;

    // HSIZE is not decoded: each register is one word and the unit
    // expects whole-word transfers only.
    wire accept;
    wire exec;

    // Every transfer takes one wait state. The data phase then sees
    // HWDATA and the freshest register contents, so a read right after
    // a write to the same register never returns stale data.
    assign accept = (state_reg == ST_IDLE) && HSEL && HTRANS[1] && HREADY;
    assign exec = (state_reg == ST_EXEC);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge MCLK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            addr_reg <= 8'h00;
            hit_reg <= 1'b0;
            write_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                addr_reg <= HADDR[7:0];
                hit_reg <= (HADDR[31:8] == 24'h000000);
                write_reg <= HWRITE;
            end
        end
    end

    // ============================================================
    // Address decode
    wire [2:0] vptr_field;
    wire [2:0] vmode;
    wire virt_ok;
    wire [1:0] vptr;
    wire [2:0] vptr_diff;

    assign vptr_field = addr_reg[`IDA_VPTR_MSB:`IDA_VPTR_LSB];
    assign vmode = addr_reg[`IDA_VMODE_MSB:`IDA_VMODE_LSB];
    // An unaligned or out-of-window address is not virtual; it falls
    // through to the physical decode, which reads it as zero unless it is a physical register offset.
    assign virt_ok = hit_reg
        && (vptr_field >= `IDA_VPTR_FIRST)
        && (vptr_field <= `IDA_VPTR_LAST)
        && (vmode <= `IDA_MODE_OFFSET)
        && (addr_reg[1:0] == 2'b00);
    // The window opens at pointer field two; take that base off
    // before the field indexes a pointer.
    assign vptr_diff = vptr_field - `IDA_VPTR_FIRST;
    assign vptr = vptr_diff[1:0];

    wire wr_exec;
    wire virt_exec;

    assign wr_exec = exec && write_reg && hit_reg;
    assign virt_exec = exec && virt_ok;

    // Register write strobes; wr_exec already requires the unit hit.
    wire wr_work;
    wire wr_bank;

    assign wr_work = wr_exec && (addr_reg == `IDA_OFF_WORK);
    assign wr_bank = wr_exec && (addr_reg == `IDA_OFF_BANK);

    // ============================================================
    // Pointer registers
    wire [AW-1:0] ptr_w [0:NPTR-1];
    reg [AW-1:0] ptr_cur;
    reg [AW-1:0] ptr_upd;
    reg [AW-1:0] ea;
    reg ptr_step;

    genvar g;
    generate
        for (g = 0; g < NPTR; g = g + 1) begin : gp
            // Each pointer owns a low and a high byte four bytes apart; pointers are eight bytes apart.
            localparam [31:0] LOW_SUM = `IDA_OFF_P0_LOW + g * 8;
            localparam [31:0] HIGH_SUM = `IDA_OFF_P0_HIGH + g * 8;

            reg [AW-1:0] p_reg;
            wire [7:0] low_off;
            wire [7:0] high_off;
            wire wr_low;
            wire wr_high;
            wire step;

            assign low_off = LOW_SUM[7:0];
            assign high_off = HIGH_SUM[7:0];
            assign ptr_w[g] = p_reg;
            assign wr_low = wr_exec && (addr_reg == low_off);
            assign wr_high = wr_exec && (addr_reg == high_off);
            assign step = virt_exec && ptr_step && (vptr == g);

            // The low byte has no defined reset value; it is cleared
            // here only so simulation starts from a known state.
            always @(posedge MCLK) begin
                if (RST) begin
                    p_reg[`IDA_HIGH_MSB:`IDA_HIGH_LSB] <= `IDA_RST_HIGH; // see [RL9] see [RL12]
                    p_reg[`IDA_LOW_MSB:`IDA_LOW_LSB] <= `IDA_RST_LOW; // see [RL10]
                end else if (wr_low) begin
                    p_reg[`IDA_LOW_MSB:`IDA_LOW_LSB] <= HWDATA[7:0]; // see [RL10]
                end else if (wr_high) begin
                    p_reg[`IDA_HIGH_MSB:`IDA_HIGH_LSB] <= HWDATA[3:0];
                end else if (step) begin
                    p_reg <= ptr_upd; // see [RL13]
                end
            end
        end
    endgenerate

    // ============================================================
    // Effective address and pointer update
    // Pointer selected by the virtual window.
    always @* begin
        case (vptr)
            2'd0: ptr_cur = ptr_w[0];
            2'd1: ptr_cur = ptr_w[1];
            default: ptr_cur = ptr_w[2];
        endcase
    end

    // Full twelve-bit add and subtract, so a step carries into or
    // borrows from the high byte.
    always @* begin
        ea = ptr_cur;
        ptr_upd = ptr_cur;
        ptr_step = 1'b0;
        case (vmode)
            `IDA_MODE_PLAIN: begin
                ea = ptr_cur; // see [RL1] see [RL8]
            end
            `IDA_MODE_AFTER_UP: begin
                ea = ptr_cur; // see [RL2]
                ptr_upd = ptr_cur + 12'h001; // see [RL13]
                ptr_step = 1'b1;
            end
            `IDA_MODE_AFTER_DOWN: begin
                ea = ptr_cur; // see [RL3]
                ptr_upd = ptr_cur - 12'h001; // see [RL13]
                ptr_step = 1'b1;
            end
            `IDA_MODE_BEFORE_UP: begin
                ptr_upd = ptr_cur + 12'h001; // see [RL4] see [RL5]
                ea = ptr_upd;
                ptr_step = 1'b1;
            end
            `IDA_MODE_OFFSET: begin
                // Unsigned add; the pointer itself is left alone.
                ea = ptr_cur + {4'h0, work_reg}; // see [RL6] see [RL7] see [RL14]
            end
            default: begin
                ea = ptr_cur;
            end
        endcase
    end

    // ============================================================
    // Data memory
    wire [7:0] mem_rdata;
    wire mem_we;

    // A virtual write stores at the effective address of this access;
    // a pointer step of the same access lands on the same edge and
    // only moves the address of the next access.
    // The data memory has no reset, so a byte never written reads
    // unknown.
    assign mem_we = virt_exec && write_reg;

    ida_dmem #(
        .AW(AW),
        .DW(8)
    ) u_dmem (
        .clk(MCLK),
        .we(mem_we),
        .addr(ea),
        .wdata(HWDATA[7:0]),
        .rdata(mem_rdata)
    );

    // ============================================================
    // Working, bank select and status registers
    reg [7:0] work_next;
    reg [3:0] bank_next;
    reg [AW-1:0] last_ea_next;

    // The working register is also the offset source, so a new value
    // takes effect from the next virtual access. Only the four
    // implemented bank bits are kept; the rest read back as zero.
    always @* begin
        work_next = work_reg;
        bank_next = BANK_SELECT;
        last_ea_next = last_ea_reg;
        if (wr_work) begin
            work_next = HWDATA[7:0];
        end
        if (wr_bank) begin
            bank_next = HWDATA[3:0];
        end
        if (virt_exec) begin
            last_ea_next = ea;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            work_reg <= `IDA_RST_WORK;
            BANK_SELECT <= `IDA_RST_BANK; // see [RL11]
            last_ea_reg <= `IDA_RST_EA;
        end else begin
            work_reg <= work_next;
            BANK_SELECT <= bank_next;
            last_ea_reg <= last_ea_next;
        end
    end

    // ============================================================
    // Read data
    reg [31:0] rd_mux;

    // Unimplemented and reserved bits, and unmapped addresses, read 0.
    // The status word gives the last effective address, so software
    // can see where a virtual access landed.
    always @* begin
        rd_mux = 32'h00000000;
        if (virt_ok) begin
            rd_mux = {24'h000000, mem_rdata};
        end else if (hit_reg) begin
            case (addr_reg)
                `IDA_OFF_P0_LOW: rd_mux = {24'h000000, ptr_w[0][7:0]};
                `IDA_OFF_P0_HIGH: rd_mux = {28'h0000000, ptr_w[0][11:8]};
                `IDA_OFF_P1_LOW: rd_mux = {24'h000000, ptr_w[1][7:0]};
                `IDA_OFF_P1_HIGH: rd_mux = {28'h0000000, ptr_w[1][11:8]};
                `IDA_OFF_P2_LOW: rd_mux = {24'h000000, ptr_w[2][7:0]};
                `IDA_OFF_P2_HIGH: rd_mux = {28'h0000000, ptr_w[2][11:8]};
                `IDA_OFF_WORK: rd_mux = {24'h000000, work_reg};
                `IDA_OFF_BANK: rd_mux = {28'h0000000, BANK_SELECT};
                `IDA_OFF_STATUS: rd_mux = {20'h00000, last_ea_reg};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // ============================================================
    // Bus outputs
    reg hreadyout_next;
    reg [31:0] hrdata_next;

    // Ready drops for the one wait state of every transfer; read data
    // is loaded as ready returns and then stands until the next read.
    always @* begin
        hreadyout_next = HREADYOUT;
        hrdata_next = HRDATA;
        if (accept) begin
            hreadyout_next = 1'b0;
        end else if (exec) begin
            hreadyout_next = 1'b1;
            if (!write_reg) begin
                hrdata_next = rd_mux;
            end
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            // Every transfer completes with an OKAY response.
            HRESP <= 1'b0;
            HREADYOUT <= hreadyout_next;
            HRDATA <= hrdata_next;
        end
    end

endmodule

// [core/ida_dmem.v]
// Data memory reached through the indirect pointers.
`timescale 1ns/10ps
module ida_dmem #(
    parameter AW = 12,
    parameter DW = 8
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output wire [DW-1:0] rdata
);

    // ============================================================
    // Storage
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read is combinational so that a virtual read and the pointer
    // update can complete in the same clock edge.
    assign rdata = mem[addr];

    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

endmodule

// [test/ida_core_asserts.sv]
// Concurrent checks on the ports of the indirect addressing unit.
`timescale 1ns/10ps
module ida_core_chk (
    input wire MCLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire [3:0] BANK_SELECT
);
    // ============================================================
    // Helpers and checks
    wire acc = HSEL && HTRANS[1] && HREADY && HREADYOUT;
    wire acc_bank = acc && HWRITE && HADDR == 32'h1c;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("slave response is not okay");
    a_one_wait: assert property (acc |=> !HREADYOUT ##1 HREADYOUT)
        else $error("transfer did not take exactly one wait state");
    a_idle_ready: assert property (HREADYOUT && !acc |=> HREADYOUT)
        else $error("ready dropped with no transfer taken");
    a_reset_clear: assert property ($fell(RST) |->
        HREADYOUT && BANK_SELECT == 4'h0 && HRDATA == 32'h0)
        else $error("outputs not cleared by reset");
    a_bank_write: assert property (acc_bank |=> ##1
        BANK_SELECT == $past(HWDATA[3:0]))
        else $error("bank select not loaded from write data");
    a_bank_hold: assert property (!$past(RST) && $changed(BANK_SELECT)
        |-> $past(acc_bank, 2))
        else $error("bank select changed without a write");
    a_rdata_hold: assert property (!$past(RST) && $changed(HRDATA)
        |-> $past(acc && !HWRITE, 2))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (acc && !HWRITE &&
        HADDR[31:8] != 24'h0 |=> ##1 HRDATA == 32'h0)
        else $error("unmapped read returned nonzero data");
    c_read: cover property (acc && !HWRITE);
    c_write: cover property (acc && HWRITE);
    c_bank: cover property (acc_bank);
endmodule

bind ida_core ida_core_chk i_chk (.MCLK, .RST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .BANK_SELECT);

// [test/ida_master.sv]
// Bus master standing in for the core's register access logic.
`timescale 1ns/10ps
module ida_master (
    input wire MCLK,
    input wire HREADY,
    input wire [31:0] HRDATA,
    output logic HSEL,
    output logic [31:0] HADDR,
    output logic [1:0] HTRANS,
    output logic HWRITE,
    output logic [2:0] HSIZE,
    output logic [31:0] HWDATA
);
    // ============================================================
    // Single word transfers; the address phase is held until ready.
    initial begin
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
    end

    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= 2'h2;
        HWRITE <= w;
        @(posedge MCLK);
        while (!HREADY) @(posedge MCLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge MCLK);
        while (!HREADY) @(posedge MCLK);
        r = HRDATA;
    endtask
endmodule

// [test/indirect_data_addressing_test.sv]
// Self-checking bench for the indirect data addressing unit.
`timescale 1ns/10ps
module indirect_data_addressing_test;
    logic MCLK = 1'b0;
    logic RST;
    wire HSEL, HWRITE, HREADYOUT, HRESP;
    wire [31:0] HADDR, HWDATA, HRDATA;
    wire [1:0] HTRANS;
    wire [2:0] HSIZE;
    wire [3:0] BANK_SELECT;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int i;
    // Row: write flag, byte offset, data written or expected.
    logic [23:0] rows [0:30] = '{24'h1100ff, 24'h114000, 24'h1840a1,
        24'h014001, 24'h0200ff, 24'h18c0b2, 24'h020101, 24'h0880b2,
        24'h1800c3, 24'h010000, 24'h0880c3, 24'h014000, 24'h0800a1,
        24'h1080fe, 24'h10c000, 24'h16c0d4, 24'h0200ff, 24'h118002,
        24'h0700b2, 24'h0080ff, 24'h020101, 24'h1000fe, 24'h104000,
        24'h0500c3, 24'h1400e5, 24'h0400e5, 24'h0000fe, 24'h120fff,
        24'h0200fe, 24'h11c01b, 24'h01c00b};
    logic [7:0] rst_regs [0:2] = '{8'h0c, 8'h14, 8'h1c};

    always #5 MCLK = ~MCLK;

    ida_core i_ida_core (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BANK_SELECT(BANK_SELECT));
    ida_master i_ida_master (.MCLK(MCLK), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));

    // ============================================================
    // Checking and closing
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task finish_test;
        $display("Counts: %0d compares, %0d errors", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // The whole run needs some 120 cycles; a hang is stopped at cycle 1000.
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            finish_test;
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        RST = 1'b1;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        for (i = 0; i < 31; i++) begin
            i_ida_master.xfer(rows[i][20], {24'h0, rows[i][19:12]},
                {20'h0, rows[i][11:0]}, rd);
            if (!rows[i][20])
                chk(rd, {20'h0, rows[i][11:0]}); // to
        end
        $display("Row test done");
        chk({28'h0, BANK_SELECT}, 32'hb);
        i_ida_master.xfer(1'b0, 32'h100, 32'h0, rd);
        chk(rd, 32'h0);
        // An unmapped write whose low byte hits the bank offset is dropped.
        i_ida_master.xfer(1'b1, 32'h11c, 32'h5, rd);
        chk({28'h0, BANK_SELECT}, 32'hb);
        i_ida_master.xfer(1'b1, 32'h0c, 32'h5, rd);
        i_ida_master.xfer(1'b1, 32'h14, 32'h5, rd);
        i_ida_master.xfer(1'b0, 32'h0c, 32'h0, rd);
        chk(rd, 32'h5);
        $display("Unmapped test done");
        // A second reset in mid-run must clear what was written above.
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        chk({28'h0, BANK_SELECT}, 32'h0);
        for (i = 0; i < 3; i++) begin
            i_ida_master.xfer(1'b0, {24'h0, rst_regs[i]}, 32'h0, rd);
            chk(rd, 32'h0);
        end
        $display("Reset test done");
        finish_test;
    end
endmodule
